//--- include/rvm_pkg.sv
// constants, types and helpers shared by the regulator voltage monitor
// assumes a 200 MHz system clock and a 100 kHz supervision time base
package rvm_pkg;
	// regulator population: bucks first, then linear regulators
	localparam int NBUCK = 7;
	localparam int NLIN  = 4;
	localparam int NREG  = NBUCK + NLIN;
	localparam int MV_W  = 16;
	localparam int IDX_W = 4;

	// clocking: the supervision time base is a one-cycle enable
	localparam int CLK_KHZ = 200000;
	localparam int LF_KHZ  = 100;
	localparam int LF_DIV  = CLK_KHZ / LF_KHZ;
	localparam int DIV_W   = 12;

	// settle time after a monitor is enabled, in us and in time-base ticks
	localparam int SETTLE_US    = 30;
	localparam int SETTLE_TICKS = (SETTLE_US * LF_KHZ + 999) / 1000;

	// filter times in us per two-bit code
	localparam int LOW_FILT_US  [4] = '{5, 15, 25, 40};
	localparam int HIGH_FILT_US [4] = '{25, 50, 80, 125};

	// trip levels in percent of nominal per two-bit code
	localparam int LOW_PCT  [4] = '{95, 93, 91, 89};
	localparam int HIGH_PCT [4] = '{105, 107, 109, 111};

	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_ENABLE = 8'h04;
	localparam logic [7:0] OFS_UNLOCK = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_ST = 8'h10;
	localparam logic [7:0] OFS_IRQ_MK = 8'h14;

	// control register layout and reset values
	localparam int         CTRL_W        = 5;
	localparam int         CTRL_LOW_LSB  = 0;
	localparam int         CTRL_HIGH_LSB = 2;
	localparam int         CTRL_SEC_BIT  = 4;
	localparam logic [1:0] LOW_FILT_RST  = 2'h2;
	localparam logic [1:0] HIGH_FILT_RST = 2'h0;
	localparam logic [4:0] CTRL_RST      = {1'h0, HIGH_FILT_RST, LOW_FILT_RST};
	localparam logic [10:0] EN_RST       = 11'h7FF;
	localparam logic [7:0] UNLOCK_KEY    = 8'hA5;

	// status layout: low trips in [10:0], high trips in [26:16]
	localparam int          STAT_HIGH_LSB = 16;
	localparam logic [31:0] STAT_VALID    = 32'h07FF_07FF;

	// stored trip-code word: low code in [1:0], high code in [3:2]
	localparam int CODE_W        = 4;
	localparam int CODE_LOW_LSB  = 0;
	localparam int CODE_HIGH_LSB = 2;

	typedef enum logic [1:0] {LD_REQ, LD_WAIT, LD_RUN} rvm_ld_t;

	// least time rounds up to whole ticks
	function automatic logic [3:0] rvm_ticks(input int us);
		return 4'((us * LF_KHZ + 999) / 1000);
	endfunction
endpackage

//--- rtl/rvm_code_mem.sv
// small memory holding the stored trip codes of every regulator
// assumes one writer and one reader on the same clock; read data registered
module rvm_code_mem #(
	parameter int DEPTH = 11,
	parameter int WIDTH = 4,
	parameter int AW    = 4
) (
	// clock
	input  wire logic             clk_i,
	// write port
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	// read port
	input  wire logic [AW-1:0]    raddr_i,
	output logic      [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem_r [DEPTH];

	// no reset: contents are defined by the start-up load
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_r[waddr_i] <= wdata_i;
		end
		rdata_o <= mem_r[raddr_i];
	end
endmodule

//--- rtl/rvm_top.sv
// overvoltage and undervoltage qualification for eleven regulators
// assumes comparators and regulator flags arrive asynchronously, the
// code store answers a read strobe one cycle later, and classic Wishbone
//
// Design decisions made here: the Wishbone register port and the register addresses.
module rvm_top
	import rvm_pkg::*;
#(
	parameter int LF_DIV_P = LF_DIV
) (
	// clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// wishbone slave
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [7:0]                wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	// trip-code store
	output logic                           otp_rd_o,
	output logic      [IDX_W-1:0]          otp_addr_o,
	input  wire logic [CODE_W-1:0]         otp_data_i,
	// regulator side, asynchronous
	input  wire logic [NREG-1:0]           reg_on_i,
	input  wire logic [NREG-1:0]           at_reg_i,
	input  wire logic [NREG-1:0]           cmp_low_i,
	input  wire logic [NREG-1:0]           cmp_high_i,
	// programmed nominal voltages, same clock
	input  wire logic [NREG-1:0][MV_W-1:0] nom_mv_i,
	// results
	output logic      [NREG-1:0]           supervision_enable_o,
	output logic      [NREG-1:0]           low_trip_status_o,
	output logic      [NREG-1:0]           high_trip_status_o,
	output logic      [NREG-1:0][MV_W-1:0] low_level_mv_o,
	output logic      [NREG-1:0][MV_W-1:0] high_level_mv_o,
	output logic                           irq_o
);
	// expand byte selects into a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// merge written lanes into an old value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [31:0] m);
		return (old & ~m) | (dat & m);
	endfunction

	// two-flop synchronisers; stage one feeds stage two only
	logic [NREG-1:0] on_s1_r, on_s_r, at_s1_r, at_s_r, lo_s1_r, lo_s_r, hi_s1_r, hi_s_r;
	logic [NREG-1:0] on_d_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{on_s1_r, on_s_r, at_s1_r, at_s_r} <= '0;
			{lo_s1_r, lo_s_r, hi_s1_r, hi_s_r} <= '0;
			on_d_r <= '0;
		end else begin
			on_s1_r <= reg_on_i;
			on_s_r  <= on_s1_r;
			at_s1_r <= at_reg_i;
			at_s_r  <= at_s1_r;
			lo_s1_r <= cmp_low_i;
			lo_s_r  <= lo_s1_r;
			hi_s1_r <= cmp_high_i;
			hi_s_r  <= hi_s1_r;
			on_d_r  <= on_s_r;
		end
	end

	// 100 kHz time base as a one-cycle enable
	logic [DIV_W-1:0] div_r, div_nxt;
	logic             tick_r, tick_nxt;

	always_comb begin
		tick_nxt = (div_r == DIV_W'(LF_DIV_P - 1));
		div_nxt  = tick_nxt ? '0 : div_r + DIV_W'(1);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			div_r  <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	// register file and bus slave state
	logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [NREG-1:0]   en_r, en_nxt, en_d_r;
	logic              armed_r, armed_nxt;
	logic [31:0]       irq_st_r, irq_st_nxt, irq_mk_r, irq_mk_nxt, dat_nxt, wmask, ev, stat_w;
	logic              ack_nxt, irq_nxt, wb_hit, wr;
	logic [NREG-1:0]   low_stat_r, low_stat_nxt, high_stat_r, high_stat_nxt;

	always_comb begin
		wb_hit     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		wr         = wb_hit & wb_we_i;
		wmask      = lane_mask(wb_sel_i);
		ctrl_nxt   = ctrl_r;
		en_nxt     = en_r;
		armed_nxt  = armed_r;
		irq_mk_nxt = irq_mk_r;
		ack_nxt    = wb_hit;
		dat_nxt    = '0;
		stat_w     = '0;
		stat_w[NREG-1:0]                       = low_stat_r;
		stat_w[STAT_HIGH_LSB +: NREG]          = high_stat_r;
		// new trips, rising edge of each flag
		ev         = '0;
		ev[NREG-1:0]              = low_stat_nxt & ~low_stat_r;
		ev[STAT_HIGH_LSB +: NREG] = high_stat_nxt & ~high_stat_r;
		irq_st_nxt = irq_st_r | ev;
		if (wr) begin
			armed_nxt = 1'b0; // any other write disarms the unlock
			case (wb_adr_i)
				OFS_CTRL: ctrl_nxt = CTRL_W'(merge(32'(ctrl_r), wb_dat_i, wmask));
				OFS_ENABLE: begin
					if (!ctrl_r[CTRL_SEC_BIT] || armed_r) begin
						en_nxt = NREG'(merge(32'(en_r), wb_dat_i, wmask));
					end
				end
				OFS_UNLOCK: armed_nxt = wb_sel_i[0] && (wb_dat_i[7:0] == UNLOCK_KEY);
				// write one to clear; a new event in the same cycle wins
				OFS_IRQ_ST: irq_st_nxt = (irq_st_r & ~(wb_dat_i & wmask)) | ev;
				OFS_IRQ_MK: irq_mk_nxt = merge(irq_mk_r, wb_dat_i, wmask) & STAT_VALID;
				default: ;
			endcase
		end else if (wb_hit) begin
			case (wb_adr_i)
				OFS_CTRL:   dat_nxt = 32'(ctrl_r);
				OFS_ENABLE: dat_nxt = 32'(en_r);
				OFS_STATUS: dat_nxt = stat_w;
				OFS_IRQ_ST: dat_nxt = irq_st_r;
				OFS_IRQ_MK: dat_nxt = irq_mk_r;
				default:    dat_nxt = '0;
			endcase
		end
		irq_st_nxt = irq_st_nxt & STAT_VALID;
		// a set mask bit hides its status bit from the interrupt line
		irq_nxt    = |(irq_st_nxt & ~irq_mk_nxt);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r   <= CTRL_RST;
			en_r     <= EN_RST;
			en_d_r   <= EN_RST;
			armed_r  <= 1'b0;
			irq_st_r <= '0;
			irq_mk_r <= '0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			irq_o    <= 1'b0;
		end else begin
			ctrl_r   <= ctrl_nxt;
			en_r     <= en_nxt;
			en_d_r   <= en_r;
			armed_r  <= armed_nxt;
			irq_st_r <= irq_st_nxt;
			irq_mk_r <= irq_mk_nxt;
			wb_ack_o <= ack_nxt;
			wb_dat_o <= dat_nxt;
			irq_o    <= irq_nxt;
		end
	end

	// per-regulator masking, settling and filtering
	logic [NREG-1:0] mask_r, mask_nxt, act;
	logic [1:0]      settle_r [NREG];
	logic [1:0]      settle_nxt [NREG];
	logic [3:0]      lcnt_r [NREG];
	logic [3:0]      lcnt_nxt [NREG];
	logic [3:0]      hcnt_r [NREG];
	logic [3:0]      hcnt_nxt [NREG];
	logic [3:0]      lt, ht;

	always_comb begin
		lt = rvm_ticks(LOW_FILT_US[ctrl_r[CTRL_LOW_LSB +: 2]]);
		ht = rvm_ticks(HIGH_FILT_US[ctrl_r[CTRL_HIGH_LSB +: 2]]);
		for (int i = 0; i < NREG; i++) begin
			// mask from switch-on until the regulation point
			mask_nxt[i] = mask_r[i];
			if (on_s_r[i] && !on_d_r[i]) begin
				mask_nxt[i] = 1'b1;
			end
			if (at_s_r[i] || !on_s_r[i]) begin
				mask_nxt[i] = 1'b0;
			end
			// comparator output not trusted right after enabling
			settle_nxt[i] = settle_r[i];
			if (en_r[i] && !en_d_r[i]) begin
				settle_nxt[i] = 2'(SETTLE_TICKS);
			end else if (tick_r && settle_r[i] != 2'h0) begin
				settle_nxt[i] = settle_r[i] - 2'h1;
			end
			// delayed copies close the one-cycle gap before mask and settle load
			act[i] = en_r[i] & en_d_r[i] & on_s_r[i] & on_d_r[i] & ~mask_r[i] &
				(settle_r[i] == 2'h0);
			// both monitors share the gating but filter separately
			lcnt_nxt[i] = lcnt_r[i];
			hcnt_nxt[i] = hcnt_r[i];
			if (!act[i] || !lo_s_r[i]) begin
				lcnt_nxt[i] = 4'h0;
			end else if (tick_r && lcnt_r[i] < lt) begin
				lcnt_nxt[i] = lcnt_r[i] + 4'h1;
			end
			if (!act[i] || !hi_s_r[i]) begin
				hcnt_nxt[i] = 4'h0;
			end else if (tick_r && hcnt_r[i] < ht) begin
				hcnt_nxt[i] = hcnt_r[i] + 4'h1;
			end
			// a zero count can never qualify, since targets are at least one tick
			low_stat_nxt[i]  = (lcnt_nxt[i] != 4'h0) && (lcnt_nxt[i] >= lt);
			high_stat_nxt[i] = (hcnt_nxt[i] != 4'h0) && (hcnt_nxt[i] >= ht);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_r      <= '0;
			low_stat_r  <= '0;
			high_stat_r <= '0;
			for (int i = 0; i < NREG; i++) begin
				settle_r[i] <= 2'(SETTLE_TICKS);
				lcnt_r[i]   <= 4'h0;
				hcnt_r[i]   <= 4'h0;
			end
		end else begin
			mask_r      <= mask_nxt;
			low_stat_r  <= low_stat_nxt;
			high_stat_r <= high_stat_nxt;
			settle_r    <= settle_nxt;
			lcnt_r      <= lcnt_nxt;
			hcnt_r      <= hcnt_nxt;
		end
	end

	assign supervision_enable_o = en_r;
	assign low_trip_status_o    = low_stat_r;
	assign high_trip_status_o   = high_stat_r;

	// start-up load of the trip codes, then a round-robin level refresh
	rvm_ld_t           ld_r, ld_nxt;
	logic [IDX_W-1:0]  idx_r, idx_nxt, dst_r, dst_nxt;
	logic              vld_r, vld_nxt, mem_we, rd_nxt;
	logic [CODE_W-1:0] code;
	logic [NREG-1:0][MV_W-1:0] lo_lvl_nxt, hi_lvl_nxt;

	rvm_code_mem #(.DEPTH(NREG), .WIDTH(CODE_W), .AW(IDX_W)) u_mem (
		.clk_i   (clk_i),
		.we_i    (mem_we),
		.waddr_i (idx_r),
		.wdata_i (otp_data_i),
		.raddr_i (idx_r),
		.rdata_o (code)
	);

	always_comb begin
		ld_nxt     = ld_r;
		idx_nxt    = idx_r;
		dst_nxt    = dst_r;
		vld_nxt    = 1'b0;
		mem_we     = 1'b0;
		lo_lvl_nxt = low_level_mv_o;
		hi_lvl_nxt = high_level_mv_o;
		case (ld_r)
			// stay until the strobe is out, so word zero is requested too
			LD_REQ: ld_nxt = otp_rd_o ? LD_WAIT : LD_REQ;
			LD_WAIT: begin
				mem_we = 1'b1;
				if (idx_r == IDX_W'(NREG - 1)) begin
					idx_nxt = '0;
					ld_nxt  = LD_RUN;
				end else begin
					idx_nxt = idx_r + IDX_W'(1);
					ld_nxt  = LD_REQ;
				end
			end
			LD_RUN: begin
				// reads only from here on, so the codes stay fixed
				vld_nxt = 1'b1;
				dst_nxt = idx_r;
				idx_nxt = (idx_r == IDX_W'(NREG - 1)) ? '0 : idx_r + IDX_W'(1);
			end
			default: ld_nxt = LD_REQ;
		endcase
		// level follows nominal within one scan of eleven cycles
		if (vld_r) begin
			lo_lvl_nxt[dst_r] = MV_W'((32'(nom_mv_i[dst_r]) *
				32'(LOW_PCT[code[CODE_LOW_LSB +: 2]])) / 32'd100);
			hi_lvl_nxt[dst_r] = MV_W'((32'(nom_mv_i[dst_r]) *
				32'(HIGH_PCT[code[CODE_HIGH_LSB +: 2]])) / 32'd100);
		end
		rd_nxt = (ld_nxt == LD_REQ);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ld_r            <= LD_REQ;
			idx_r           <= '0;
			dst_r           <= '0;
			vld_r           <= 1'b0;
			otp_rd_o        <= 1'b0;
			otp_addr_o      <= '0;
			low_level_mv_o  <= '0;
			high_level_mv_o <= '0;
		end else begin
			ld_r            <= ld_nxt;
			idx_r           <= idx_nxt;
			dst_r           <= dst_nxt;
			vld_r           <= vld_nxt;
			otp_rd_o        <= rd_nxt;
			otp_addr_o      <= idx_nxt;
			low_level_mv_o  <= lo_lvl_nxt;
			high_level_mv_o <= hi_lvl_nxt;
		end
	end

	// checks on the design's own behaviour
	AST_EN_RESET: assert property (@(posedge clk_i) rst_i |=> en_r == EN_RST)
		else $error("enables not all set after reset");
	AST_LOW_FILT_RESET: assert property (@(posedge clk_i)
		rst_i |=> ctrl_r[CTRL_LOW_LSB +: 2] == 2'h2)
		else $error("low filter field not 10 after reset");
	AST_HIGH_FILT_RESET: assert property (@(posedge clk_i)
		rst_i |=> ctrl_r[CTRL_HIGH_LSB +: 2] == 2'h0)
		else $error("high filter field not 00 after reset");
	AST_SECURE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && wb_adr_i == OFS_ENABLE && ctrl_r[CTRL_SEC_BIT] && !armed_r) |=> $stable(en_r))
		else $error("enable changed without unlock");
	AST_DISABLE_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
		!en_r[0] |=> !low_stat_r[0] && !high_stat_r[0])
		else $error("status survived disable");
	AST_MASKED: assert property (@(posedge clk_i) disable iff (rst_i)
		mask_r[3] |=> !high_stat_r[3] && !low_stat_r[3])
		else $error("trip during start-up mask");
	AST_SETTLING: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(en_r[2]) |=> (settle_r[2] == 2'h3) ##1 !low_stat_r[2] [*3])
		else $error("result used while settling");
	AST_QUALIFY: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(low_stat_r[0]) |-> $past(lo_s_r[0]) && lcnt_r[0] >= $past(lt))
		else $error("low trip without full filter time");
	AST_CODES_FIXED: assert property (@(posedge clk_i) disable iff (rst_i)
		ld_r == LD_RUN |=> ld_r == LD_RUN && !mem_we)
		else $error("trip codes rewritten after load");
endmodule

//--- verif/rvm_far_model.sv
// far-side model: trip-code store and regulator start-up ramps
// assumes the block strobes one code read at a time on clk_i
module rvm_far_model
	import rvm_pkg::*;
#(
	parameter int RAMP = 40
) (
	// clock
	input  wire logic              clk_i,
	// code store
	input  wire logic              otp_rd_i,
	input  wire logic [IDX_W-1:0]  otp_addr_i,
	output logic      [CODE_W-1:0] otp_data_o,
	// regulators
	input  wire logic [NREG-1:0]   pwr_i,
	output logic      [NREG-1:0]   reg_on_o,
	output logic      [NREG-1:0]   at_reg_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int ramp_cnt [NREG];
	initial begin
		otp_data_o = 4'h0;
		at_reg_o = '1;
		foreach (ramp_cnt[k]) ramp_cnt[k] = RAMP;
	end
	assign reg_on_o = pwr_i;
	// word valid one edge after the strobe only; toggles otherwise
	always @(posedge clk_i) begin
		if (otp_rd_i) otp_data_o <= {otp_addr_i[1:0] + 2'h1, otp_addr_i[1:0]};
		else otp_data_o <= ~otp_data_o;
	end
	// regulation point reached RAMP cycles after turn-on
	always @(posedge clk_i) begin
		for (int k = 0; k < NREG; k++) begin
			if (!pwr_i[k]) ramp_cnt[k] <= 0;
			else if (ramp_cnt[k] < RAMP) ramp_cnt[k] <= ramp_cnt[k] + 1;
			at_reg_o[k] <= pwr_i[k] && ramp_cnt[k] >= RAMP;
		end
	end
endmodule

//--- verif/tb_rvm_top.sv
// self-checking bench for the regulator voltage monitor
// assumes the far-side model and a fast time base of LF cycles per tick
module tb_rvm_top
	import rvm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LF = 4;
	localparam int RAMP = 40;
	logic clk_i, rst_i, cyc, stb, we, ack, irq, otp_rd;
	logic [7:0] adr;
	logic [3:0] sel, otp_data;
	logic [IDX_W-1:0] otp_addr;
	logic [31:0] dwr, drd;
	logic [NREG-1:0] pwr, reg_on, at_reg, cmp_lo, cmp_hi, en, lo_s, hi_s;
	logic [NREG-1:0][MV_W-1:0] nom, lo_lv, hi_lv;
	int mismatches, n_checks, cyc_cnt;

	rvm_top #(.LF_DIV_P(LF)) u_rvm_top (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack), .otp_rd_o(otp_rd),
		.otp_addr_o(otp_addr), .otp_data_i(otp_data), .reg_on_i(reg_on),
		.at_reg_i(at_reg), .cmp_low_i(cmp_lo), .cmp_high_i(cmp_hi), .nom_mv_i(nom),
		.supervision_enable_o(en), .low_trip_status_o(lo_s), .high_trip_status_o(hi_s),
		.low_level_mv_o(lo_lv), .high_level_mv_o(hi_lv), .irq_o(irq));
	rvm_far_model #(.RAMP(RAMP)) u_rvm_far_model (.clk_i(clk_i), .otp_rd_i(otp_rd),
		.otp_addr_i(otp_addr), .otp_data_o(otp_data), .pwr_i(pwr),
		.reg_on_o(reg_on), .at_reg_o(at_reg));

	// 200 MHz clock
	initial begin
		clk_i = 1'h0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// hang guard, well above the expected run length
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int n, input int lo, input int hi);
		n_checks++;
		if (n < lo || n > hi) begin
			mismatches++;
			$display("CHECK FAILED t=%0t delay %0d not in %0d..%0d", $time, n, lo, hi);
		end
	endtask
	// classic single cycle; held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dwr <= d;
		sel <= 4'hF;
		do @(posedge clk_i); while (ack !== 1'h1);
		q = drd;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'h1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'h0, a, 32'h0, q);
		chk(q, exp);
	endtask
	// cycles from the current edge until a flag rises
	task automatic wflag(input bit h, input int i, input int lo, input int hi);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((h ? hi_s[i] : lo_s[i]) !== 1'h1 && n <= hi);
		chk_rng(n, lo, hi);
	endtask
	// optional short glitch first, which must restart the filter
	task automatic trip(input bit h, input int i, input int n, input bit g);
		logic [31:0] b;
		b = 32'h1 << (i + (h ? STAT_HIGH_LSB : 0));
		if (g) begin
			@(posedge clk_i);
			cmp_lo[i] <= 1'h1;
			repeat (8) @(posedge clk_i);
			cmp_lo[i] <= 1'h0;
			repeat (2) @(posedge clk_i);
		end
		@(posedge clk_i);
		if (h) cmp_hi[i] <= 1'h1;
		else cmp_lo[i] <= 1'h1;
		wflag(h, i, (n - 1) * LF + 1, n * LF + 6);
		rd(OFS_STATUS, b);
		chk(irq, 1'h1);
		@(posedge clk_i);
		cmp_hi[i] <= 1'h0;
		cmp_lo[i] <= 1'h0;
		repeat (6) @(posedge clk_i);
		rd(OFS_STATUS, 32'h0);
		rd(OFS_IRQ_ST, b);
		wr(OFS_IRQ_ST, b);
		rd(OFS_IRQ_ST, 32'h0);
		chk(irq, 1'h0);
	endtask
	task automatic chk_lv();
		for (int i = 0; i < NREG; i++) begin
			chk(32'(lo_lv[i]), 32'(int'(nom[i]) * LOW_PCT[i % 4] / 100));
			chk(32'(hi_lv[i]), 32'(int'(nom[i]) * HIGH_PCT[(i + 1) % 4] / 100));
		end
	endtask

	initial begin
		{cyc, stb, we, adr, sel, dwr} = '0;
		{cmp_lo, cmp_hi} = '0;
		pwr = '1;
		rst_i = 1'h1;
		for (int i = 0; i < NREG; i++) nom[i] = 16'(1000 + 100 * i);
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		rd(OFS_CTRL, 32'h2);
		rd(OFS_ENABLE, 32'h7FF);
		chk(32'(en), 32'h7FF);
		rd(OFS_IRQ_MK, 32'h0);
		rd(8'h40, 32'h0);
		repeat (40) @(posedge clk_i);
		chk_lv();
		@(posedge clk_i);
		for (int i = 0; i < NREG; i++) nom[i] <= nom[i] + 16'h00FA;
		repeat (20) @(posedge clk_i);
		chk_lv();
		// every filter code, bucks on the low side, linear on the high side
		for (int c = 0; c < 4; c++) begin
			wr(OFS_CTRL, 32'(c * 5));
			trip(1'h0, c, (LOW_FILT_US[c] + 9) / 10, 1'h0);
			trip(1'h1, 7 + c, (HIGH_FILT_US[c] + 9) / 10, 1'h0);
		end
		trip(1'h0, 5, 4, 1'h1);
		wr(OFS_CTRL, 32'h0);
		@(posedge clk_i);
		cmp_lo[2] <= 1'h1;
		wflag(1'h0, 2, 1, LF + 6);
		wr(OFS_ENABLE, 32'h7FB);
		repeat (20) @(posedge clk_i);
		chk(32'(lo_s), 32'h0);
		chk(32'(en), 32'h7FB);
		wr(OFS_ENABLE, 32'h7FF);
		wflag(1'h0, 2, 2 * LF, 4 * LF + 8);
		cmp_lo[2] <= 1'h0;
		repeat (6) @(posedge clk_i);
		wr(OFS_IRQ_ST, 32'h07FF_07FF);
		// locked enables need the unlock key right before
		wr(OFS_CTRL, 32'h10);
		wr(OFS_ENABLE, 32'h0);
		rd(OFS_ENABLE, 32'h7FF);
		wr(OFS_UNLOCK, 32'hA5);
		wr(OFS_ENABLE, 32'h7FE);
		rd(OFS_ENABLE, 32'h7FE);
		wr(OFS_UNLOCK, 32'hA5);
		wr(OFS_CTRL, 32'h10);
		wr(OFS_ENABLE, 32'h7FF);
		rd(OFS_ENABLE, 32'h7FE);
		wr(OFS_UNLOCK, 32'hA5);
		wr(OFS_ENABLE, 32'h7FF);
		wr(OFS_CTRL, 32'h0);
		// turn-on masking until the regulation point
		@(posedge clk_i);
		pwr[3] <= 1'h0;
		repeat (4) @(posedge clk_i);
		pwr[3] <= 1'h1;
		cmp_hi[3] <= 1'h1;
		wflag(1'h1, 3, RAMP, RAMP + 3 * LF + 10);
		cmp_hi[3] <= 1'h0;
		repeat (6) @(posedge clk_i);
		wr(OFS_IRQ_ST, 32'h07FF_07FF);
		// masked interrupt stays low, unmasking raises it
		wr(OFS_IRQ_MK, 32'h07FF_07FF);
		cmp_lo[6] <= 1'h1;
		wflag(1'h0, 6, 1, LF + 6);
		rd(OFS_IRQ_ST, 32'h40);
		chk(irq, 1'h0);
		wr(OFS_IRQ_MK, 32'h0);
		repeat (2) @(posedge clk_i);
		chk(irq, 1'h1);
		test_done();
	end
endmodule
